// ### logic/flic_defs.vh
// Constants for the four level interrupt controller.
// Assumes an 8-bit special register port and one system clock.
`ifndef FLIC_DEFS_VH
`define FLIC_DEFS_VH

// Source count and widths
`define FLIC_NSRC        23
`define FLIC_VW          5
`define FLIC_BASE_N      7

// Register offsets on the special register port
`define FLIC_OFS_EN0     8'hc0
`define FLIC_OFS_PLO0    8'hc1
`define FLIC_OFS_PHI0    8'hc2
`define FLIC_OFS_EN1     8'hc3
`define FLIC_OFS_PLO1    8'hc4
`define FLIC_OFS_PHI1    8'hc5
`define FLIC_OFS_EN2     8'hc6
`define FLIC_OFS_PLO2    8'hed
`define FLIC_OFS_PHI2    8'hf6
`define FLIC_OFS_PEND0   8'hc8
`define FLIC_OFS_PEND1   8'hc9
`define FLIC_OFS_PEND2   8'hca
`define FLIC_OFS_STAT    8'hcb

// Field positions
`define FLIC_GIE_BIT     7
`define FLIC_STAT_BUSY   7
`define FLIC_STAT_REQ    6

// Reset values
`define FLIC_RST_EN      8'h00
`define FLIC_RST_PRIO    8'h00
`define FLIC_RST_PEND    8'h00

// Latency figures, in system clock cycles
`define FLIC_DETECT_CYC  1
`define FLIC_CALL_CYC    4
`define FLIC_RETURN_CYC  5
`define FLIC_DIV_CYC     8
`define FLIC_BEST_CYC    (`FLIC_DETECT_CYC + `FLIC_CALL_CYC)
`define FLIC_WORST_CYC   (`FLIC_BEST_CYC + `FLIC_RETURN_CYC + `FLIC_DIV_CYC)
`define FLIC_CNT_W       3

`endif

// ### logic/flic_arbiter.v
// Priority resolver for the interrupt controller.
// Purely combinational; the caller registers the result each cycle.
`timescale 1ns/1ps
`include "flic_defs.vh"

module flic_arbiter (
	req,
	prio_hi,
	prio_lo,
	found,
	vec,
	lvl
);
	input  wire [`FLIC_NSRC-1:0]   req;
	input  wire [`FLIC_NSRC-1:0]   prio_hi;
	input  wire [`FLIC_NSRC-1:0]   prio_lo;
	output reg                     found;
	output reg  [`FLIC_VW-1:0]     vec;
	output reg  [1:0]              lvl;

	wire [2*`FLIC_NSRC-1:0] lvl_of;
	integer i;

	genvar g;
	generate
		for (g = 0; g < `FLIC_NSRC; g = g + 1) begin : g_lvl
			// High bit then low bit, 00 lowest, 11 highest
			assign lvl_of[2*g+1:2*g] = {prio_hi[g], prio_lo[g]};
		end
	endgenerate

	// Scan downward with >= so a lower vector wins a tie
	always @* begin
		found = 1'b0;
		vec = {`FLIC_VW{1'b0}};
		lvl = 2'b00;
		for (i = `FLIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (req[i] && (!found || lvl_of[2*i+1 -: 2] >= lvl)) begin
				found = 1'b1;
				vec = i[`FLIC_VW-1:0];
				lvl = lvl_of[2*i+1 -: 2];
			end
		end
	end
endmodule

// ### logic/flic_ctrl.v
// Four level interrupt controller: pending flags, enables, priority,
// preemption and the vector call handshake towards the CPU sequencer.
// Assumes the CPU pulses instr_end at each ordinary instruction end,
// return_end at the end of a return, and never both in one cycle.
//
// Behaviour
// - A source event sets its pending flag whatever the enables say.
// - Enabled pending source requests; call starts at next instruction end.
// - Return resumes the interrupted flow; controller retires one level.
// - Request needs own enable and global enable; global zero blocks all.
// - Auto-clear flags clear on vectoring; software clears the others.
// - Flag still set after return requests again at once.
// - Software writing one to a pending flag acts like a hardware event.
// - Every source has four levels from two priority bits.
// - Low priority bit from low registers, high bit from high registers.
// - Only strictly higher level preempts; topmost level is never preempted.
// - After reset every source sits at the lowest level.
// - Simultaneous requests: highest configured level granted first.
// - Equal level ties go to the smaller vector number.
// - Requests sampled every cycle; best response is one plus four cycles.
// - Request pending at return waits for one more instruction.
// - Worst response bounded by detect, return, divide and call cycles.
// - Equal or lower request waits for return plus one instruction.
// - On routine exit the highest pending request goes next.
`timescale 1ns/1ps
`include "flic_defs.vh"

module flic_ctrl (
	ref_clk,
	reset_n,
	src_event,
	src_auto_clr,
	sfr_addr,
	sfr_wr,
	sfr_wdata,
	sfr_rdata,
	cpu_instr_end,
	cpu_return_end,
	irq_req,
	call_start,
	call_busy,
	call_vector,
	call_level,
	in_service
);
	input  wire                  ref_clk;
	input  wire                  reset_n;
	input  wire [`FLIC_NSRC-1:0] src_event;
	input  wire [`FLIC_NSRC-1:0] src_auto_clr;
	input  wire [7:0]            sfr_addr;
	input  wire                  sfr_wr;
	input  wire [7:0]            sfr_wdata;
	output reg  [7:0]            sfr_rdata;
	input  wire                  cpu_instr_end;
	input  wire                  cpu_return_end;
	output wire                  irq_req;
	output wire                  call_start;
	output wire                  call_busy;
	output reg  [`FLIC_VW-1:0]   call_vector;
	output reg  [1:0]            call_level;
	output reg  [3:0]            in_service;

	localparam ST_IDLE = 1'b0;
	localparam ST_CALL = 1'b1;

	localparam [`FLIC_CNT_W-1:0] CALL_LAST = `FLIC_CALL_CYC - 1;

	// Enable, priority and pending registers
	reg [7:0]               base_irq_enable_reg;
	reg [7:0]               ext_irq_enable_1;
	reg [7:0]               ext_irq_enable_2;
	reg [7:0]               base_priority_low_reg;
	reg [7:0]               base_priority_high_reg;
	reg [7:0]               ext_priority_group1_low;
	reg [7:0]               ext_priority_group1_high;
	reg [7:0]               ext_priority_group2_low;
	reg [7:0]               ext_priority_group2_high;
	reg [`FLIC_NSRC-1:0]    pending;

	// Sequencer state
	reg                     state;
	reg [`FLIC_CNT_W-1:0]   call_cnt;
	reg                     det_valid;
	reg [`FLIC_VW-1:0]      det_vec;
	reg [1:0]               det_lvl;

	reg [`FLIC_NSRC-1:0]    next_pending;
	reg [`FLIC_NSRC-1:0]    sw_pend;
	reg [`FLIC_NSRC-1:0]    sw_pend_we;
	reg [`FLIC_NSRC-1:0]    vec_clr;
	reg [3:0]               next_in_service;
	reg [3:0]               retire_mask;

	wire                    global_irq_enable;
	wire [`FLIC_NSRC-1:0]   enables;
	wire [`FLIC_NSRC-1:0]   prio_lo;
	wire [`FLIC_NSRC-1:0]   prio_hi;
	wire [`FLIC_NSRC-1:0]   requests;
	wire                    arb_found;
	wire [`FLIC_VW-1:0]     arb_vec;
	wire [1:0]              arb_lvl;
	wire [3:0]              at_or_above;
	wire                    preempt_ok;
	wire [7:0]              status;

	assign global_irq_enable = base_irq_enable_reg[`FLIC_GIE_BIT];

	assign enables = {ext_irq_enable_2,
		ext_irq_enable_1,
		base_irq_enable_reg[`FLIC_BASE_N-1:0]};

	assign prio_lo = {ext_priority_group2_low,
		ext_priority_group1_low,
		base_priority_low_reg[`FLIC_BASE_N-1:0]};

	assign prio_hi = {ext_priority_group2_high,
		ext_priority_group1_high,
		base_priority_high_reg[`FLIC_BASE_N-1:0]};

	// Global enable gates every source, individual enable each one
	assign requests = pending & enables &
		{`FLIC_NSRC{global_irq_enable}};

	flic_arbiter flic_arbiter_inst (
		.req     (requests),
		.prio_hi (prio_hi),
		.prio_lo (prio_lo),
		.found   (arb_found),
		.vec     (arb_vec),
		.lvl     (arb_lvl)
	);

	// Detection stage: one cycle of sampling and decode, every cycle
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			det_valid <= 1'b0;
			det_vec <= {`FLIC_VW{1'b0}};
			det_lvl <= 2'b00;
		end else begin
			det_valid <= arb_found;
			det_vec <= arb_vec;
			det_lvl <= arb_lvl;
		end
	end

	// Levels in service at or above the candidate block it
	assign at_or_above = in_service &
		~((4'h1 << det_lvl) - 4'h1);

	// Strict greater only, so level 3 can never be preempted
	assign preempt_ok = ~|at_or_above;

	assign irq_req = det_valid && preempt_ok;

	// Calls start only at an ordinary instruction end. A return end is
	// never a call point, so one further instruction always runs first.
	assign call_start = (state == ST_IDLE) && irq_req &&
		cpu_instr_end;

	assign call_busy = (state == ST_CALL);

	// Vector call sequencer, four cycles long
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			call_cnt <= {`FLIC_CNT_W{1'b0}};
			call_vector <= {`FLIC_VW{1'b0}};
			call_level <= 2'b00;
		end else begin
			case (state)
				ST_IDLE: begin
					call_cnt <= {`FLIC_CNT_W{1'b0}};
					if (call_start) begin
						state <= ST_CALL;
						call_vector <= det_vec;
						call_level <= det_lvl;
					end
				end
				ST_CALL: begin
					if (call_cnt == CALL_LAST) begin
						state <= ST_IDLE;
						call_cnt <= {`FLIC_CNT_W{1'b0}};
					end else begin
						call_cnt <= call_cnt + 1'b1;
					end
				end
				default: begin
					state <= ST_IDLE;
					call_cnt <= {`FLIC_CNT_W{1'b0}};
				end
			endcase
		end
	end

	// Highest level in service retires on a return
	always @* begin
		retire_mask = 4'h0;
		if (in_service[3])
			retire_mask = 4'h8;
		else if (in_service[2])
			retire_mask = 4'h4;
		else if (in_service[1])
			retire_mask = 4'h2;
		else if (in_service[0])
			retire_mask = 4'h1;
	end

	always @* begin
		next_in_service = in_service;
		if (cpu_return_end)
			next_in_service = next_in_service & ~retire_mask;
		if (call_start)
			next_in_service = next_in_service |
				(4'h1 << det_lvl);
	end

	always @(posedge ref_clk) begin
		if (!reset_n)
			in_service <= 4'h0;
		else
			in_service <= next_in_service;
	end

	// Software view of the pending flags
	always @* begin
		sw_pend = {`FLIC_NSRC{1'b0}};
		sw_pend_we = {`FLIC_NSRC{1'b0}};
		if (sfr_wr) begin
			case (sfr_addr)
				`FLIC_OFS_PEND0: begin
					sw_pend[`FLIC_BASE_N-1:0] =
						sfr_wdata[`FLIC_BASE_N-1:0];
					sw_pend_we[`FLIC_BASE_N-1:0] =
						{`FLIC_BASE_N{1'b1}};
				end
				`FLIC_OFS_PEND1: begin
					sw_pend[14:7] = sfr_wdata;
					sw_pend_we[14:7] = 8'hff;
				end
				`FLIC_OFS_PEND2: begin
					sw_pend[22:15] = sfr_wdata;
					sw_pend_we[22:15] = 8'hff;
				end
				default: begin
					sw_pend = {`FLIC_NSRC{1'b0}};
				end
			endcase
		end
	end

	// Auto-clear flags drop when their call starts
	always @* begin
		vec_clr = {`FLIC_NSRC{1'b0}};
		if (call_start)
			vec_clr[det_vec] = src_auto_clr[det_vec];
	end

	// Software writes apply first, then auto clear, then events win
	always @* begin
		next_pending = (pending & ~sw_pend_we) | (sw_pend & sw_pend_we);
		next_pending = next_pending & ~vec_clr;
		next_pending = next_pending | src_event;
	end

	always @(posedge ref_clk) begin
		if (!reset_n)
			pending <= {`FLIC_NSRC{1'b0}};
		else
			pending <= next_pending;
	end

	// Enable and priority register writes
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			base_irq_enable_reg <= `FLIC_RST_EN;
			ext_irq_enable_1 <= `FLIC_RST_EN;
			ext_irq_enable_2 <= `FLIC_RST_EN;
			base_priority_low_reg <= `FLIC_RST_PRIO;
			base_priority_high_reg <= `FLIC_RST_PRIO;
			ext_priority_group1_low <= `FLIC_RST_PRIO;
			ext_priority_group1_high <= `FLIC_RST_PRIO;
			ext_priority_group2_low <= `FLIC_RST_PRIO;
			ext_priority_group2_high <= `FLIC_RST_PRIO;
		end else if (sfr_wr) begin
			case (sfr_addr)
				`FLIC_OFS_EN0:
					base_irq_enable_reg <= sfr_wdata;
				`FLIC_OFS_EN1:
					ext_irq_enable_1 <= sfr_wdata;
				`FLIC_OFS_EN2:
					ext_irq_enable_2 <= sfr_wdata;
				`FLIC_OFS_PLO0:
					base_priority_low_reg <= sfr_wdata;
				`FLIC_OFS_PHI0:
					base_priority_high_reg <= sfr_wdata;
				`FLIC_OFS_PLO1:
					ext_priority_group1_low <= sfr_wdata;
				`FLIC_OFS_PHI1:
					ext_priority_group1_high <= sfr_wdata;
				`FLIC_OFS_PLO2:
					ext_priority_group2_low <= sfr_wdata;
				`FLIC_OFS_PHI2:
					ext_priority_group2_high <= sfr_wdata;
				default: begin
					base_irq_enable_reg <= base_irq_enable_reg;
				end
			endcase
		end
	end

	// Status shows the sequencer and the levels in service
	assign status = {call_busy, irq_req, 2'b00, in_service};

	// Read data is registered, valid the cycle after the address
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			sfr_rdata <= 8'h00;
		end else begin
			case (sfr_addr)
				`FLIC_OFS_EN0:
					sfr_rdata <= base_irq_enable_reg;
				`FLIC_OFS_EN1:
					sfr_rdata <= ext_irq_enable_1;
				`FLIC_OFS_EN2:
					sfr_rdata <= ext_irq_enable_2;
				`FLIC_OFS_PLO0:
					sfr_rdata <= base_priority_low_reg;
				`FLIC_OFS_PHI0:
					sfr_rdata <= base_priority_high_reg;
				`FLIC_OFS_PLO1:
					sfr_rdata <= ext_priority_group1_low;
				`FLIC_OFS_PHI1:
					sfr_rdata <= ext_priority_group1_high;
				`FLIC_OFS_PLO2:
					sfr_rdata <= ext_priority_group2_low;
				`FLIC_OFS_PHI2:
					sfr_rdata <= ext_priority_group2_high;
				`FLIC_OFS_PEND0:
					sfr_rdata <= {1'b0,
						pending[`FLIC_BASE_N-1:0]};
				`FLIC_OFS_PEND1:
					sfr_rdata <= pending[14:7];
				`FLIC_OFS_PEND2:
					sfr_rdata <= pending[22:15];
				`FLIC_OFS_STAT:
					sfr_rdata <= status;
				default:
					sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// ### sim/flic_ctrl_sva.sv
// Assertion checker for the interrupt controller ports.
// Assumes it is bound to flic_ctrl from the bench; sees ports only.
`timescale 1ns/1ps
module flic_ctrl_sva (
	input wire       ref_clk,
	input wire       reset_n,
	input wire       cpu_instr_end,
	input wire       cpu_return_end,
	input wire       irq_req,
	input wire       call_start,
	input wire       call_busy,
	input wire [1:0] call_level,
	input wire [3:0] in_service
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_start_cause: assert property (
		call_start |-> irq_req && cpu_instr_end)
		else $error("call start without request");
	a_busy_span: assert property (
		call_start |=> call_busy [*4] ##1 !call_busy)
		else $error("call sequence not four cycles");
	a_busy_blocks: assert property (
		call_busy |-> !call_start)
		else $error("call started during call");
	a_no_return_call: assert property (
		cpu_return_end |-> !call_start)
		else $error("call started on return");
	a_top_level: assert property (
		in_service[3] |-> !irq_req)
		else $error("top level preempted");
	a_level_marked: assert property (
		call_start |=> in_service[call_level])
		else $error("call level not in service");
	// Shift leaves only the levels at or above the new call
	a_strict_pre: assert property (
		call_start |=> ($past(in_service) >> call_level) == 4'h0)
		else $error("preemption not strictly higher");
	a_return_retires: assert property (
		cpu_return_end && in_service != 4'h0 |=>
		$countones(in_service) == $countones($past(in_service)) - 1)
		else $error("return did not retire one level");
endmodule

// ### sim/flic_cpu_model.sv
// Behavioural CPU sequencer: instruction ends, returns, call stalls.
// Assumes the bench asks for a return by a one-cycle ret_go pulse.
`timescale 1ns/1ps
module flic_cpu_model (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire       run,
	input  wire [3:0] gap,
	input  wire       ret_go,
	input  wire       call_start,
	input  wire       call_busy,
	output reg        cpu_instr_end,
	output reg        cpu_return_end
);
	reg [3:0] cnt;
	reg       ret_pend;

	always @(posedge ref_clk) begin
		cpu_instr_end <= 1'b0;
		cpu_return_end <= 1'b0;
		if (!reset_n) begin
			cnt <= 4'h0;
			ret_pend <= 1'b0;
		end else begin
			if (ret_go)
				ret_pend <= 1'b1;
			// No instruction ends while the vector call runs
			if (call_busy || call_start || !run)
				cnt <= gap;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
			else begin
				cnt <= gap;
				if (ret_pend) begin
					cpu_return_end <= 1'b1;
					ret_pend <= 1'b0;
				end else
					cpu_instr_end <= 1'b1;
			end
		end
	end
endmodule

// ### sim/tb_flic_ctrl.sv
// Self-checking bench for the interrupt controller.
// Assumes flic_ctrl, the CPU model and the checker are compiled first.
`timescale 1ns/1ps
`include "flic_defs.vh"
module tb_flic_ctrl;
	reg                  ref_clk;
	reg                  reset_n;
	reg [`FLIC_NSRC-1:0] src_event;
	reg [`FLIC_NSRC-1:0] src_auto_clr;
	reg [7:0]            sfr_addr;
	reg                  sfr_wr;
	reg [7:0]            sfr_wdata;
	reg                  run;
	reg [3:0]            gap;
	reg                  ret_go;
	wire [7:0]           sfr_rdata;
	wire                 cpu_instr_end;
	wire                 cpu_return_end;
	wire                 irq_req;
	wire                 call_start;
	wire                 call_busy;
	wire [`FLIC_VW-1:0]  call_vector;
	wire [1:0]           call_level;
	wire [3:0]           in_service;
	integer              errors;
	integer              n_tests;
	integer              lat;
	integer              i;
	localparam [111:0] OFS = {8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5,
		8'hc6, 8'hed, 8'hf6, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'h80};

	flic_ctrl flic_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.src_event(src_event), .src_auto_clr(src_auto_clr),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .cpu_instr_end(cpu_instr_end),
		.cpu_return_end(cpu_return_end), .irq_req(irq_req),
		.call_start(call_start), .call_busy(call_busy),
		.call_vector(call_vector), .call_level(call_level),
		.in_service(in_service));
	flic_cpu_model flic_cpu_model_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .run(run), .gap(gap), .ret_go(ret_go),
		.call_start(call_start), .call_busy(call_busy),
		.cpu_instr_end(cpu_instr_end), .cpu_return_end(cpu_return_end));

	task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("ERROR %0s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
		// Idle cycle so a following write never re-raises the strobe at once
		@(negedge ref_clk);
	endtask
	task rd(input [7:0] a, input [7:0] e);
		sfr_addr = a;
		@(negedge ref_clk);
		chk("sfr", e, sfr_rdata);
	endtask
	// Bounded wait for a call, then its registered vector and level
	task call(input [4:0] v, input [1:0] l);
		lat = 0;
		while (call_start !== 1'b1 && lat < 40) begin
			@(negedge ref_clk);
			lat = lat + 1;
		end
		chk("start", 8'h01, {7'h0, call_start});
		@(negedge ref_clk);
		chk("vector", {3'h0, v}, {3'h0, call_vector});
		chk("level", {6'h0, l}, {6'h0, call_level});
	endtask
	task ret_svc;
		ret_go = 1'b1;
		@(negedge ref_clk);
		ret_go = 1'b0;
	endtask
	task results;
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		errors = errors + 1;
		results;
	end
	initial begin
		{reset_n, src_event, src_auto_clr, sfr_addr, sfr_wr} = 0;
		{sfr_wdata, gap, ret_go, errors, n_tests} = 0;
		run = 1'b1;
		repeat (3) @(negedge ref_clk);
		reset_n = 1'b1;
		wr(8'h80, 8'hff);
		for (i = 0; i < 14; i = i + 1)
			rd(OFS[111-8*i -: 8], 8'h00);
		wr(8'hed, 8'ha5);
		wr(8'hf6, 8'h5a);
		rd(8'hed, 8'ha5);
		rd(8'hf6, 8'h5a);
		wr(8'hf6, 8'h00);
		rd(8'hf6, 8'h00);
		wr(`FLIC_OFS_EN0, 8'h08);
		src_event[3] = 1'b1;
		@(negedge ref_clk);
		src_event[3] = 1'b0;
		rd(`FLIC_OFS_PEND0, 8'h08);
		repeat (3) @(negedge ref_clk);
		chk("irq", 8'h00, {7'h0, irq_req});
		wr(`FLIC_OFS_EN0, 8'h88);
		call(5'd3, 2'd0);
		wr(`FLIC_OFS_PEND0, 8'h00);
		ret_svc;
		repeat (8) @(negedge ref_clk);
		rd(`FLIC_OFS_STAT, 8'h00);
		src_event[3] = 1'b1;
		@(negedge ref_clk);
		src_event[3] = 1'b0;
		call(5'd3, 2'd0);
		chk("latency", 8'h01, lat[7:0]);
		ret_svc;
		call(5'd3, 2'd0);
		chk("worst", 8'h01, {7'h0, lat <= `FLIC_WORST_CYC});
		wr(`FLIC_OFS_PEND0, 8'h00);
		ret_svc;
		repeat (8) @(negedge ref_clk);
		// Stalled CPU makes all seven requests simultaneous
		src_auto_clr = {`FLIC_NSRC{1'b1}};
		run = 1'b0;
		gap = 4'h3;
		wr(`FLIC_OFS_EN0, 8'hff);
		wr(`FLIC_OFS_PLO0, 8'h20);
		wr(`FLIC_OFS_PHI0, 8'h40);
		wr(`FLIC_OFS_PEND0, 8'h7f);
		run = 1'b1;
		call(5'd6, 2'd2);
		ret_svc;
		call(5'd5, 2'd1);
		ret_svc;
		call(5'd0, 2'd0);
		rd(`FLIC_OFS_PEND0, 8'h1e);
		wr(`FLIC_OFS_PLO0, 8'h22);
		wr(`FLIC_OFS_PHI0, 8'h42);
		call(5'd1, 2'd3);
		repeat (6) @(negedge ref_clk);
		chk("insvc", 8'h09, {4'h0, in_service});
		wr(`FLIC_OFS_PEND0, 8'h5c);
		repeat (8) @(negedge ref_clk);
		chk("irq", 8'h00, {7'h0, irq_req});
		ret_svc;
		call(5'd6, 2'd2);
		results;
	end
endmodule

bind flic_ctrl flic_ctrl_sva flic_ctrl_sva_inst (.ref_clk(ref_clk),
	.reset_n(reset_n), .cpu_instr_end(cpu_instr_end),
	.cpu_return_end(cpu_return_end), .irq_req(irq_req),
	.call_start(call_start), .call_busy(call_busy),
	.call_level(call_level), .in_service(in_service));
